// *** pbtr_fifo.sv ***
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module pbtr_fifo #(
    parameter int W = 1,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    pbtr_stream_if.snk inPort,
    pbtr_stream_if.src outPort
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign inPort.ready = (count_q != FULL);
    assign outPort.valid = (count_q != '0);
    assign outPort.data = mem_q[rdPtr_q];
    assign push = inPort.valid && inPort.ready;
    assign pop = outPort.valid && outPort.ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inPort.data;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** pbtr_frame_ram.sv ***
// Multi-frame bit buffer: one write port, two registered read ports
`timescale 1ns/100ps
`default_nettype none
module pbtr_frame_ram #(
    parameter int AW = 11
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic wrBit,
    input wire logic rdAEn,
    input wire logic [AW-1:0] rdAAddr,
    output logic rdABit,
    input wire logic rdBEn,
    input wire logic [AW-1:0] rdBAddr,
    output logic rdBBit
);
    logic [(2**AW)-1:0] mem_q;

    // No reset on storage: only locked frames are ever read back
    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            mem_q[wrAddr] <= wrBit;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdABit <= 1'b0;
            rdBBit <= 1'b0;
        end else begin
            if (rdAEn) begin
                rdABit <= mem_q[rdAAddr];
            end
            if (rdBEn) begin
                rdBBit <= mem_q[rdBAddr];
            end
        end
    end
endmodule
`default_nettype wire

// *** pbtr_pkg.sv ***
// Shared constants and types for the playback track recovery block
`default_nettype none
package pbtr_pkg;

    localparam int NUM_TRACKS = 36;
    localparam int TRK_SEL_W = 6;

    // Frame layout: header (sync, time code, status, parity) then data groups
    localparam int SYNC_BITS = 32;
    localparam logic [SYNC_BITS-1:0] SYNC_WORD = 32'h3c5a_a5c3;
    localparam int TIME_BITS = 16;
    localparam int HDR_BITS = 64;
    localparam int HDR_AW = 6;
    localparam int GROUP_DATA = 8;
    localparam int DATA_GROUPS = 32;
    localparam int DATA_AW = 8;
    localparam int FRAME_LEN = HDR_BITS + DATA_GROUPS * (GROUP_DATA + 1);
    localparam int POS_W = 9;
    localparam logic [POS_W-1:0] POS_LAST = POS_W'(FRAME_LEN - 1);
    localparam logic [POS_W-1:0] POS_HDR_LAST = POS_W'(HDR_BITS - 1);
    localparam logic [POS_W-1:0] POS_TIME_FIRST = POS_W'(SYNC_BITS);
    localparam logic [POS_W-1:0] POS_TIME_LAST = POS_W'(SYNC_BITS + TIME_BITS - 1);
    localparam logic [HDR_AW-1:0] HDR_OFF_LAST = HDR_AW'(HDR_BITS - 1);
    localparam logic [3:0] GRP_PARITY_SLOT = 4'(GROUP_DATA);
    localparam logic PARITY_ODD = 1'b1;

    // Buffer RAM: several whole frames, header and data halves per frame
    localparam int FRAME_W = 2;
    localparam int RAM_AW = FRAME_W + 1 + DATA_AW;
    localparam int SAMPLE_W = FRAME_W + DATA_AW;
    localparam int HDR_RD_W = FRAME_W + HDR_AW;

    localparam int ERR_W = 16;
    localparam logic [1:0] MISS_LIMIT = 2'h3;

    // Output bit rate from the core clock
    localparam int SYS_CLK_HZ = 25_000_000;
    localparam int OUT_RATE_HZ = 8_000_000;
    localparam int OUT_DIV = SYS_CLK_HZ / OUT_RATE_HZ;
    localparam int DIV_W = 2;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OUT_DIV - 1);

    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = 1;

    typedef enum logic [1:0] {
        LOCK_SEEK = 2'b00,
        LOCK_HELD = 2'b01,
        LOCK_COAST = 2'b11
    } pbtr_lock_t;

endpackage
`default_nettype wire

// *** pbtr_stream_if.sv ***
// Valid/ready stream carrier between block modules
`timescale 1ns/100ps
`default_nettype none
interface pbtr_stream_if #(
    parameter int W = 1
) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** pbtr_tape_model.sv ***
// Behavioural tape playback unit driving the selected track pair
`timescale 1ns/100ps
`default_nettype none
module pbtr_tape_model (
    input wire logic [pbtr_pkg::TRK_SEL_W-1:0] sel,
    output logic [pbtr_pkg::NUM_TRACKS-1:0] trackData,
    output logic [pbtr_pkg::NUM_TRACKS-1:0] trackClk
);
    int nBits;
    logic lastBit;
    initial begin
        trackData = '0;
        trackClk = '0;
        nBits = 0;
        lastBit = 1'b0;
    end
    //////////////////////////////////////////////////
    // Wobbling half period, never below two core cycles
    task automatic bit_out(input logic b);
        int half;
        logic [pbtr_pkg::NUM_TRACKS-1:0] nxt;
        half = 150 + (nBits % 3) * 10;
        nxt = {trackData[pbtr_pkg::NUM_TRACKS-2:0], ~trackData[0]};
        nxt[sel] = b;
        trackData = nxt;
        trackClk[sel] = 1'b0;
        #(half);
        trackClk[sel] = 1'b1;
        #(half);
        nBits++;
        lastBit = b;
    endtask
    task automatic send_frame(input logic [15:0] tc, input logic [255:0] d,
            input logic [31:0] badGrp, input logic badHdr, input logic badSync);
        logic [63:0] hdr;
        hdr = {pbtr_pkg::SYNC_WORD ^ {32{badSync}}, tc, 15'h0, 1'b0};
        hdr[0] = ~(^hdr[63:1]) ^ badHdr;
        for (int i = 63; i >= 0; i--) begin
            bit_out(hdr[i]);
        end
        for (int g = 0; g < 32; g++) begin
            for (int j = 0; j < 8; j++) begin
                bit_out(d[g * 8 + j]);
            end
            bit_out(~(^d[g * 8 +: 8]) ^ badGrp[g]);
        end
        // Line left unreliable once the frame ends
        trackData[sel] = ~lastBit;
        // Idle gap so the next frame never moves the pin in the same step
        #(160);
    endtask
endmodule
`default_nettype wire

// *** pbtr_track_recovery.sv ***
// Playback track recovery: sync, frame counters, parity strip, frame buffer
//
// Behaviour
// - Any of up to 36 data/clock track pairs may be selected and recovered.
// - Input side runs off edges of the selected track's own clock.
// - Head skew between tracks is absorbed by time-addressed buffer writes.
// - Data leaves as a bit stream at the fixed system rate, stalled by consumer back-pressure.
// - Incoming bits are compared continuously against the frame sync word.
// - Sync detection initialises frame counters that predict the next sync.
// - Frame counters advance per track bit and form the RAM write address.
// - Buffer RAM holds several whole frames for delay and rate smoothing.
// - Read addresses for delayed data come from the external delay model.
// - Write frame base derives from the previous header's time code.
// - Data portion stores data bits only; parity checked, counted, dropped.
// - Every header bit is written into the RAM.
// - Header parity is checked when header bits are read back.
// - Delayed data reads walk data addresses and skip header addresses.
// - A second read port returns stored header bits.
`timescale 1ns/100ps
`default_nettype none
module pbtr_track_recovery #(
    parameter int NUM_TRACKS = pbtr_pkg::NUM_TRACKS,
    parameter logic [pbtr_pkg::SYNC_BITS-1:0] SYNC_WORD = pbtr_pkg::SYNC_WORD,
    parameter int FIFO_DEPTH = pbtr_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [NUM_TRACKS-1:0] trackData,
    input wire logic [NUM_TRACKS-1:0] trackClk,
    input wire logic [pbtr_pkg::TRK_SEL_W-1:0] trackSel,
    input wire logic delayLoad,
    input wire logic [pbtr_pkg::SAMPLE_W-1:0] delayValue,
    output logic dataOut,
    output logic dataOutValid,
    input wire logic dataOutReady,
    input wire logic hdrRdEn,
    input wire logic [pbtr_pkg::HDR_RD_W-1:0] hdrRdAddr,
    output logic hdrBit,
    output logic hdrBitValid,
    output logic hdrCheckDone,
    output logic hdrParityErr,
    input wire logic parityErrClear,
    output logic [pbtr_pkg::ERR_W-1:0] parityErrCount,
    output logic trackValid,
    output logic syncMiss
);

    ////////////////////////////////////////////////////////////////////////
    // Track pin synchronisers

    logic [NUM_TRACKS-1:0] dataSync;
    logic [NUM_TRACKS-1:0] clkSync;

    for (genvar gi = 0; gi < NUM_TRACKS; gi++) begin : gTrk
        logic [1:0] dSh_q;
        logic [1:0] cSh_q;
        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                dSh_q <= 2'h0;
                cSh_q <= 2'h0;
            end else begin
                dSh_q <= {dSh_q[0], trackData[gi]};
                cSh_q <= {cSh_q[0], trackClk[gi]};
            end
        end
        assign dataSync[gi] = dSh_q[1];
        assign clkSync[gi] = cSh_q[1];
    end

    // Out-of-range selections read as an idle track
    function automatic logic pickTrack(
        input logic [NUM_TRACKS-1:0] v,
        input logic [pbtr_pkg::TRK_SEL_W-1:0] s
    );
        logic r;
        r = 1'b0;
        for (int i = 0; i < NUM_TRACKS; i++) begin
            if (s == pbtr_pkg::TRK_SEL_W'(i)) begin
                r = v[i];
            end
        end
        return r;
    endfunction

    logic selData;
    logic selClk;
    logic clkPrev_q;
    logic [pbtr_pkg::TRK_SEL_W-1:0] trackSel_q;
    logic selChange;
    logic bitEvt;
    logic bitEvt_q;

    assign selData = pickTrack(dataSync, trackSel);
    assign selClk = pickTrack(clkSync, trackSel);
    assign selChange = (trackSel != trackSel_q);
    // Rising edge of the track's own clock; tolerates any rate below clk/2
    assign bitEvt = selClk && !clkPrev_q && !selChange;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clkPrev_q <= 1'b0;
            trackSel_q <= '0;
            bitEvt_q <= 1'b0;
        end else begin
            clkPrev_q <= selClk;
            trackSel_q <= trackSel;
            bitEvt_q <= bitEvt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sync detection and frame lock

    logic [pbtr_pkg::SYNC_BITS-1:0] sh_q;
    logic outBit;
    logic syncHit;
    logic predictNow;
    pbtr_pkg::pbtr_lock_t lock_q;
    logic [1:0] miss_q;
    logic [pbtr_pkg::POS_W-1:0] pos_q;

    // Compare window is also a delay line, so sync bits get stored too
    assign outBit = sh_q[pbtr_pkg::SYNC_BITS-1];
    assign syncHit = bitEvt_q && (sh_q == SYNC_WORD);
    assign predictNow = bitEvt_q && (lock_q != pbtr_pkg::LOCK_SEEK) && (pos_q == '0);
    assign trackValid = (lock_q != pbtr_pkg::LOCK_SEEK);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sh_q <= '0;
        end else if (bitEvt) begin
            sh_q <= {sh_q[pbtr_pkg::SYNC_BITS-2:0], selData};
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_q <= pbtr_pkg::LOCK_SEEK;
            miss_q <= 2'h0;
            syncMiss <= 1'b0;
        end else begin
            syncMiss <= predictNow && !syncHit;
            if (selChange) begin
                lock_q <= pbtr_pkg::LOCK_SEEK;
                miss_q <= 2'h0;
            end else if (syncHit) begin
                lock_q <= pbtr_pkg::LOCK_HELD;
                miss_q <= 2'h0;
            end else if (predictNow) begin
                // Coast through isolated dropouts rather than lose the frame
                if (miss_q == pbtr_pkg::MISS_LIMIT - 2'h1) begin
                    lock_q <= pbtr_pkg::LOCK_SEEK;
                    miss_q <= 2'h0;
                end else begin
                    lock_q <= pbtr_pkg::LOCK_COAST;
                    miss_q <= miss_q + 2'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame counters and time code

    logic isHdr;
    logic [3:0] grp_q;
    logic [pbtr_pkg::DATA_AW-1:0] dataOff_q;
    logic [pbtr_pkg::TIME_BITS-1:0] timeSh_q;
    logic [pbtr_pkg::TIME_BITS-1:0] timeCode_q;
    logic timeValid_q;
    logic [pbtr_pkg::FRAME_W-1:0] frame_q;
    logic [pbtr_pkg::FRAME_W-1:0] nextFrame;
    logic inTime;

    assign isHdr = (pos_q <= pbtr_pkg::POS_HDR_LAST);
    assign inTime = (pos_q >= pbtr_pkg::POS_TIME_FIRST) && (pos_q <= pbtr_pkg::POS_TIME_LAST);
    // Time code counts frames; its low bits pick the frame slot in RAM
    assign nextFrame = timeValid_q ? timeCode_q[pbtr_pkg::FRAME_W-1:0] + 1'b1
                                   : frame_q + 1'b1;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pos_q <= '0;
        end else if (syncHit) begin
            pos_q <= '0;
        end else if (bitEvt) begin
            pos_q <= (pos_q == pbtr_pkg::POS_LAST) ? '0 : pos_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_q <= '0;
        end else if (syncHit || predictNow) begin
            frame_q <= nextFrame;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            grp_q <= 4'h0;
            dataOff_q <= '0;
        end else if (bitEvt) begin
            if (isHdr) begin
                grp_q <= 4'h0;
                dataOff_q <= '0;
            end else if (grp_q == pbtr_pkg::GRP_PARITY_SLOT) begin
                grp_q <= 4'h0;
            end else begin
                grp_q <= grp_q + 4'h1;
                dataOff_q <= dataOff_q + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            timeSh_q <= '0;
            timeCode_q <= '0;
            timeValid_q <= 1'b0;
        end else if (lock_q == pbtr_pkg::LOCK_SEEK) begin
            timeValid_q <= 1'b0;
        end else if (bitEvt && inTime) begin
            timeSh_q <= {timeSh_q[pbtr_pkg::TIME_BITS-2:0], outBit};
            if (pos_q == pbtr_pkg::POS_TIME_LAST) begin
                timeCode_q <= {timeSh_q[pbtr_pkg::TIME_BITS-2:0], outBit};
                timeValid_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RAM write path and along-track parity

    logic ramWe;
    logic [pbtr_pkg::RAM_AW-1:0] ramWAddr;
    logic isParity;
    logic parAcc_q;
    logic parErr;

    assign isParity = !isHdr && (grp_q == pbtr_pkg::GRP_PARITY_SLOT);
    assign ramWe = bitEvt && trackValid && !isParity;
    assign ramWAddr = isHdr
        ? {frame_q, 1'b0, pbtr_pkg::DATA_AW'(pos_q[pbtr_pkg::HDR_AW-1:0])}
        : {frame_q, 1'b1, dataOff_q};
    assign parErr = bitEvt && trackValid && isParity
        && ((parAcc_q ^ outBit) != pbtr_pkg::PARITY_ODD);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            parAcc_q <= 1'b0;
        end else if (bitEvt) begin
            parAcc_q <= (isHdr || isParity) ? 1'b0 : parAcc_q ^ outBit;
        end
    end

    // New error in the clearing cycle still counts
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            parityErrCount <= '0;
        end else if (parErr) begin
            if (parityErrClear) begin
                parityErrCount <= pbtr_pkg::ERR_W'(1);
            end else if (parityErrCount != '1) begin
                parityErrCount <= parityErrCount + 1'b1;
            end
        end else if (parityErrClear) begin
            parityErrCount <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Delayed data read side and output FIFO

    logic [pbtr_pkg::DIV_W-1:0] div_q;
    logic tick;
    logic pending_q;
    logic armed_q;
    logic inFlight_q;
    logic issue;
    logic [pbtr_pkg::SAMPLE_W-1:0] rdPtr_q;
    logic [pbtr_pkg::RAM_AW-1:0] rdAAddr;
    logic rdABit;
    logic [pbtr_pkg::RAM_AW-1:0] rdBAddr;
    logic rdBBit;

    pbtr_stream_if #(.W(pbtr_pkg::FIFO_W)) fifoIn ();
    pbtr_stream_if #(.W(pbtr_pkg::FIFO_W)) fifoOut ();

    assign tick = (div_q == pbtr_pkg::DIV_LAST);
    // Back-pressure from the consumer stalls RAM reads, never drops bits
    assign issue = pending_q && armed_q && trackValid && fifoIn.ready && !inFlight_q;
    assign rdAAddr = {rdPtr_q[pbtr_pkg::SAMPLE_W-1:pbtr_pkg::DATA_AW], 1'b1,
                      rdPtr_q[pbtr_pkg::DATA_AW-1:0]};

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= '0;
        end else begin
            div_q <= tick ? '0 : div_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pending_q <= 1'b0;
            inFlight_q <= 1'b0;
        end else begin
            pending_q <= tick || (pending_q && !issue);
            inFlight_q <= issue;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdPtr_q <= '0;
            armed_q <= 1'b0;
        end else if (delayLoad) begin
            rdPtr_q <= delayValue;
            armed_q <= 1'b1;
        end else if (issue) begin
            rdPtr_q <= rdPtr_q + 1'b1;
        end
    end

    assign fifoIn.valid = inFlight_q;
    assign fifoIn.data = rdABit;
    assign dataOut = fifoOut.data;
    assign dataOutValid = fifoOut.valid;
    assign fifoOut.ready = dataOutReady;

    ////////////////////////////////////////////////////////////////////////
    // Header read port with deferred parity check

    logic hdrRdEn_q;
    logic [pbtr_pkg::HDR_AW-1:0] hdrOff_q;
    logic hdrAcc_q;
    logic hdrSum;

    assign rdBAddr = {hdrRdAddr[pbtr_pkg::HDR_RD_W-1:pbtr_pkg::HDR_AW], 1'b0,
                      pbtr_pkg::DATA_AW'(hdrRdAddr[pbtr_pkg::HDR_AW-1:0])};
    assign hdrBit = rdBBit;
    assign hdrBitValid = hdrRdEn_q;
    assign hdrSum = ((hdrOff_q == '0) ? 1'b0 : hdrAcc_q) ^ rdBBit;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hdrRdEn_q <= 1'b0;
            hdrOff_q <= '0;
            hdrAcc_q <= 1'b0;
            hdrCheckDone <= 1'b0;
            hdrParityErr <= 1'b0;
        end else begin
            hdrRdEn_q <= hdrRdEn;
            hdrOff_q <= hdrRdAddr[pbtr_pkg::HDR_AW-1:0];
            hdrCheckDone <= hdrRdEn_q && (hdrOff_q == pbtr_pkg::HDR_OFF_LAST);
            hdrParityErr <= hdrRdEn_q && (hdrOff_q == pbtr_pkg::HDR_OFF_LAST)
                && (hdrSum != pbtr_pkg::PARITY_ODD);
            if (hdrRdEn_q) begin
                hdrAcc_q <= hdrSum;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Submodules

    // Several frames deep so a delay of up to a few frames fits
    pbtr_frame_ram #(
        .AW(pbtr_pkg::RAM_AW)
    ) uRam (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .wrEn(ramWe),
        .wrAddr(ramWAddr),
        .wrBit(outBit),
        .rdAEn(issue),
        .rdAAddr(rdAAddr),
        .rdABit(rdABit),
        .rdBEn(hdrRdEn),
        .rdBAddr(rdBAddr),
        .rdBBit(rdBBit)
    );

    pbtr_fifo #(
        .W(pbtr_pkg::FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) uFifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .inPort(fifoIn),
        .outPort(fifoOut)
    );

endmodule
`default_nettype wire

// *** pbtr_track_recovery_bench.sv ***
// Self-checking bench for the track recovery block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH at %0t got %h exp %h", $time, g, e); end end
module pbtr_track_recovery_bench;
    logic core_clk = 1'b0;
    logic arst_n, delayLoad, dataOutReady, hdrRdEn, parityErrClear;
    logic dataOut, dataOutValid, hdrBit, hdrBitValid, hdrCheckDone, hdrParityErr;
    logic trackValid, syncMiss;
    logic missSeen = 1'b0;
    logic [pbtr_pkg::TRK_SEL_W-1:0] trackSel;
    logic [pbtr_pkg::SAMPLE_W-1:0] delayValue;
    logic [pbtr_pkg::HDR_RD_W-1:0] hdrRdAddr;
    logic [pbtr_pkg::ERR_W-1:0] parityErrCount;
    wire [pbtr_pkg::NUM_TRACKS-1:0] trackData;
    wire [pbtr_pkg::NUM_TRACKS-1:0] trackClk;
    logic [255:0] dat [0:4];
    logic [31:0] bad;
    int seed = 32'h4f1d;
    int fails = 0;
    int nChecks = 0;
    int cycles = 0;
    int total = 0;
    int k;
    always #20 core_clk = ~core_clk;
    pbtr_tape_model i_tape (.sel(trackSel), .trackData(trackData), .trackClk(trackClk));
    pbtr_track_recovery i_dut (.core_clk(core_clk), .arst_n(arst_n), .trackData(trackData),
        .trackClk(trackClk), .trackSel(trackSel), .delayLoad(delayLoad),
        .delayValue(delayValue), .dataOut(dataOut), .dataOutValid(dataOutValid),
        .dataOutReady(dataOutReady), .hdrRdEn(hdrRdEn), .hdrRdAddr(hdrRdAddr),
        .hdrBit(hdrBit), .hdrBitValid(hdrBitValid), .hdrCheckDone(hdrCheckDone),
        .hdrParityErr(hdrParityErr), .parityErrClear(parityErrClear),
        .parityErrCount(parityErrCount), .trackValid(trackValid), .syncMiss(syncMiss));
    //////////////////////////////////////////////////
    function automatic logic exp_hdr(input logic [15:0] tc, input logic b, input int off);
        logic [63:0] h;
        h = {pbtr_pkg::SYNC_WORD, tc, 15'h0, 1'b0};
        h[0] = ~(^h[63:1]) ^ b;
        return h[63 - off];
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic hdr_read(input logic [1:0] idx, input logic [15:0] tc, input logic b);
        for (int a = 0; a <= 65; a++) begin
            @(negedge core_clk);
            if (a > 0 && a < 65) begin
                `CHK(hdrBit, exp_hdr(tc, b, a - 1))
            end
            if (a == 65) begin
                `CHK(hdrCheckDone, 1'b1)
                `CHK(hdrParityErr, b)
            end
            hdrRdEn = (a < 64);
            hdrRdAddr = {idx, 6'(a)};
        end
    endtask
    always @(negedge core_clk) begin
        if (syncMiss === 1'b1) begin
            missSeen <= 1'b1;
        end
        cycles++;
        // Frames plus reads need about 20000 cycles
        if (cycles == 40000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        arst_n = 0;
        {delayLoad, dataOutReady, hdrRdEn, parityErrClear} = 4'h0;
        delayValue = '0;
        hdrRdAddr = '0;
        trackSel = 6'($unsigned($random(seed)) % 36);
        repeat (2) @(negedge core_clk);
        arst_n = 1;
        repeat (3) @(negedge core_clk);
        `CHK(trackValid, 1'b0)
        for (int f = 0; f < 5; f++) begin
            for (int w = 0; w < 8; w++) begin
                dat[f][w * 32 +: 32] = $random(seed);
            end
            bad = (f == 2) ? 32'h8000_0001 : (f == 3) ? ($random(seed) & 32'h00ff_0000) : 0;
            total += $countones(bad);
            i_tape.send_frame(16'(f), dat[f], bad, 1'(f == 3), 1'b0);
        end
        repeat (8) @(negedge core_clk);
        `CHK(trackValid, 1'b1)
        `CHK(parityErrCount, 16'(total))
        parityErrClear = 1;
        @(negedge core_clk);
        parityErrClear = 0;
        @(negedge core_clk);
        `CHK(parityErrCount, 16'h0)
        // Supervisor pass over the headers of frames 1 to 4
        for (int i = 1; i <= 4; i++) begin
            hdr_read(2'(i), 16'(i), 1'(i == 3));
        end
        `CHK(dataOutValid, 1'b0)
        delayLoad = 1;
        delayValue = {2'h1, 8'h00};
        @(negedge core_clk);
        delayLoad = 0;
        // Consumer stalls first so the FIFO fills and refuses
        repeat (40) @(negedge core_clk);
        k = 0;
        for (int c = 0; c < 3000 && k < 300; c++) begin
            @(negedge core_clk);
            dataOutReady = ($random(seed) % 4) != 0;
            if (dataOutReady && dataOutValid === 1'b1) begin
                `CHK(dataOut, dat[1 + k / 256][k % 256])
                k++;
            end
        end
        dataOutReady = 0;
        `CHK(k, 300)
        i_tape.send_frame(16'h5, dat[0], 32'h0, 1'b0, 1'b1);
        repeat (8) @(negedge core_clk);
        `CHK(missSeen, 1'b1)
        `CHK(trackValid, 1'b1)
        trackSel = 6'((trackSel + 1) % 36);
        repeat (3) @(negedge core_clk);
        `CHK(trackValid, 1'b0)
        final_report();
    end
endmodule
`default_nettype wire

// *** pbtr_track_recovery_chk.sv ***
// Port checks for the track recovery block
`timescale 1ns/100ps
`default_nettype none
module pbtr_track_recovery_chk (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [pbtr_pkg::TRK_SEL_W-1:0] trackSel,
    input wire logic dataOut,
    input wire logic dataOutValid,
    input wire logic dataOutReady,
    input wire logic hdrRdEn,
    input wire logic [pbtr_pkg::HDR_RD_W-1:0] hdrRdAddr,
    input wire logic hdrBitValid,
    input wire logic hdrCheckDone,
    input wire logic hdrParityErr,
    input wire logic parityErrClear,
    input wire logic [pbtr_pkg::ERR_W-1:0] parityErrCount,
    input wire logic trackValid
);
    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic seenLock_q;
    logic lastRd;
    assign lastRd = hdrRdEn && hdrRdAddr[5:0] == 6'h3f;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            seenLock_q <= 1'b0;
        end else if (trackValid) begin
            seenLock_q <= 1'b1;
        end
    end
    sequence s_last_read;
        lastRd;
    endsequence
    sequence s_check_pulse;
        ##2 hdrCheckDone;
    endsequence
    //////////////////////////////////////////////////
    a_hdr_read_echo: assert property (hdrRdEn |=> hdrBitValid)
        else $error("header read without valid strobe");
    a_hdr_idle_quiet: assert property (!hdrRdEn |=> !hdrBitValid)
        else $error("header valid strobe without read");
    a_check_after_last: assert property (s_last_read |-> s_check_pulse)
        else $error("no header check after last offset");
    a_check_has_cause: assert property (hdrCheckDone |-> $past(lastRd, 2))
        else $error("header check without last offset read");
    a_err_with_done: assert property (hdrParityErr |-> hdrCheckDone)
        else $error("header parity error outside check pulse");
    a_count_steps: assert property (!parityErrClear |=>
        ({1'b0, parityErrCount} - {1'b0, $past(parityErrCount)}) <= 17'h1)
        else $error("parity count jumped or wrapped");
    a_clear_empties: assert property (parityErrClear |=> parityErrCount <= 16'h0001)
        else $error("parity count not cleared");
    a_quiet_before_lock: assert property (!seenLock_q |-> !dataOutValid)
        else $error("output valid before first lock");
    a_stream_holds: assert property (dataOutValid && !dataOutReady |=>
        dataOutValid && $stable(dataOut))
        else $error("output bit dropped while stalled");
    a_sel_drops_lock: assert property ($changed(trackSel) |-> ##[1:2] !trackValid)
        else $error("lock kept across track change");
endmodule
bind pbtr_track_recovery pbtr_track_recovery_chk i_chk (
    .core_clk(core_clk), .arst_n(arst_n), .trackSel(trackSel), .dataOut(dataOut),
    .dataOutValid(dataOutValid), .dataOutReady(dataOutReady), .hdrRdEn(hdrRdEn),
    .hdrRdAddr(hdrRdAddr), .hdrBitValid(hdrBitValid), .hdrCheckDone(hdrCheckDone),
    .hdrParityErr(hdrParityErr), .parityErrClear(parityErrClear),
    .parityErrCount(parityErrCount), .trackValid(trackValid));
`default_nettype wire
